//--- core/scr_config_regs.sv
// Serial-bus slave holding the slew, id and byte count registers
//
// Notes on behaviour
// - Output slew bits 5/3, default fast
// - Feedback slew bit 0, default fast
// - Byte 4 always reads all ones
// - Fixed revision and maker code byte
// - Fixed part class and part number byte
// - Byte count field is sent as the count byte; the host's NACK sets read length
// - Read: count byte first, then data
`timescale 1ns/1ps
`include "scr_params.svh"

module scr_config_regs
    import scr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic edge_speed_out1_o,
    output logic edge_speed_out0_o,
    output logic edge_speed_feedback_o,
    output logic [4:0] readback_length_o
);

    // Register readback for one byte location
    function automatic logic [7:0] scr_read(
        input logic [7:0] idx,
        input logic o1,
        input logic o0,
        input logic fbk_bit,
        input logic [4:0] bc
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `SCR_OFF_DIFF_SLEW: begin
                v = `SCR_RSVD_DIFF;
                v[`SCR_BIT_OUT1] = o1;
                v[`SCR_BIT_OUT0] = o0;
            end
            `SCR_OFF_FBK_SLEW: begin
                v = `SCR_RSVD_FBK;
                v[`SCR_BIT_FBK] = fbk_bit;
            end
            `SCR_OFF_RSVD: v = `SCR_RSVD_BYTE;
            `SCR_OFF_REV_VENDOR: v = {`SCR_REVISION, `SCR_VENDOR};
            `SCR_OFF_TYPE_ID: v = {`SCR_PART_CLASS, `SCR_PART_NUMBER};
            `SCR_OFF_BYTE_COUNT: v = {3'h0, bc};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Pin synchronisers and filtered levels
    logic [2:0] scl_ff; // Three-stage chain on clock pin
    logic [2:0] sda_ff; // Three-stage chain on data pin
    logic scl_f; // Filtered clock level
    logic sda_f; // Filtered data level
    logic scl_q; // Previous filtered clock
    logic sda_q; // Previous filtered data
    logic [2:0] next_scl_ff;
    logic [2:0] next_sda_ff;
    logic next_scl_f;
    logic next_sda_f;

    // Protocol state
    scr_state_t state; // Serial engine state
    scr_kind_t kind; // Role of byte being received
    logic [2:0] bit_cnt; // Bit position inside a byte
    logic [7:0] shreg; // Shift register for both directions
    logic rd_mode; // Current transfer is a read
    logic [7:0] index; // Current byte location
    logic oe; // Pulls the data line low
    logic out1; // Output 1 edge speed
    logic out0; // Output 0 edge speed
    logic fbk; // Feedback edge speed
    logic [4:0] bc; // Programmed read length
    scr_state_t next_state;
    scr_kind_t next_kind;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shreg;
    logic next_rd_mode;
    logic [7:0] next_index;
    logic next_oe;
    logic next_out1;
    logic next_out0;
    logic next_fbk;
    logic [4:0] next_bc;

    // Bus events from filtered levels
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_ev = scl_f & scl_q & ~sda_q & sda_f;

    // Filter: level changes once stages two and three agree
    always_comb begin
        next_scl_ff = {scl_ff[1:0], scl_i};
        next_sda_ff = {sda_ff[1:0], sda_i};
        next_scl_f = scl_f;
        next_sda_f = sda_f;
        if (scl_ff[1] == scl_ff[2]) begin
            next_scl_f = scl_ff[2];
        end
        if (sda_ff[1] == sda_ff[2]) begin
            next_sda_f = sda_ff[2];
        end
    end

    // Filter registers; idle bus is high
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_ff <= 3'h7;
            sda_ff <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_ff <= next_scl_ff;
            sda_ff <= next_sda_ff;
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // Serial engine and register writes
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rd_mode = rd_mode;
        next_index = index;
        next_oe = oe;
        next_out1 = out1;
        next_out0 = out0;
        next_fbk = fbk;
        next_bc = bc;
        if (stop_ev) begin
            // Stop ends any transfer
            next_state = SCR_IDLE;
            next_oe = 1'b0;
        end else if (start_ev) begin
            // Start or repeated start: expect address
            next_state = SCR_RX;
            next_kind = SCR_K_ADDR;
            next_bit_cnt = 3'h0;
            next_oe = 1'b0;
        end else begin
            unique case (state)
                SCR_IDLE: begin
                    next_oe = 1'b0;
                end
                SCR_RX: begin
                    // Sample data on clock rise, msb first
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_f};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            next_state = SCR_RXEND;
                        end
                    end
                end
                SCR_RXEND: begin
                    // Byte complete: act on it, then acknowledge
                    if (scl_fall) begin
                        next_oe = 1'b1;
                        next_state = SCR_ACK;
                        unique case (kind)
                            SCR_K_ADDR: begin
                                if (shreg[7:1] == `SCR_SLAVE_ADDR) begin
                                    next_rd_mode = shreg[0];
                                    next_kind = SCR_K_INDEX;
                                end else begin
                                    // Not ours: stay off the bus
                                    next_oe = 1'b0;
                                    next_state = SCR_IDLE;
                                end
                            end
                            SCR_K_INDEX: begin
                                next_index = shreg;
                                next_kind = SCR_K_COUNT;
                            end
                            SCR_K_COUNT: begin
                                // Host's count; data length follows stop
                                next_kind = SCR_K_DATA;
                            end
                            SCR_K_DATA: begin
                                // Only defined fields take data
                                unique case (index)
                                    `SCR_OFF_DIFF_SLEW: begin
                                        next_out1 = shreg[`SCR_BIT_OUT1];
                                        next_out0 = shreg[`SCR_BIT_OUT0];
                                    end
                                    `SCR_OFF_FBK_SLEW: begin
                                        next_fbk = shreg[`SCR_BIT_FBK];
                                    end
                                    `SCR_OFF_BYTE_COUNT: begin
                                        next_bc = shreg[`SCR_BC_MSB:0];
                                    end
                                    default: begin
                                        next_bc = bc;
                                    end
                                endcase
                                next_index = index + 8'h01;
                            end
                        endcase
                    end
                end
                SCR_ACK: begin
                    // End of acknowledge slot
                    if (scl_fall) begin
                        next_bit_cnt = 3'h0;
                        if (kind == SCR_K_INDEX && rd_mode) begin
                            // Read answers with byte count first
                            next_shreg = {3'h0, bc};
                            // First bit is the count byte's msb, always zero
                            next_oe = ~next_shreg[7];
                            next_state = SCR_TX;
                        end else begin
                            next_oe = 1'b0;
                            next_state = SCR_RX;
                        end
                    end
                end
                SCR_TX: begin
                    // Shift out next bit on each clock fall
                    if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            next_oe = 1'b0;
                            next_state = SCR_RACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_oe = ~shreg[6];
                        end
                    end
                end
                SCR_RACK: begin
                    // Host acknowledge sampled on rise
                    if (scl_rise) begin
                        next_rd_mode = ~sda_f;
                    end
                    if (scl_fall) begin
                        if (rd_mode) begin
                            // Acked: send data from current location
                            next_shreg = scr_read(index, out1, out0, fbk,
                                                  bc);
                            next_oe = ~next_shreg[7];
                            next_index = index + 8'h01;
                            next_bit_cnt = 3'h0;
                            next_state = SCR_TX;
                        end else begin
                            // Not acknowledged: wait for stop
                            next_state = SCR_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = SCR_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // Engine registers with documented defaults
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= SCR_IDLE;
            kind <= SCR_K_ADDR;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            index <= 8'h00;
            oe <= 1'b0;
            out1 <= `SCR_RST_OUT1;
            out0 <= `SCR_RST_OUT0;
            fbk <= `SCR_RST_FBK;
            bc <= `SCR_RST_BC;
        end else begin
            state <= next_state;
            kind <= next_kind;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rd_mode <= next_rd_mode;
            index <= next_index;
            oe <= next_oe;
            out1 <= next_out1;
            out0 <= next_out0;
            fbk <= next_fbk;
            bc <= next_bc;
        end
    end

    // Open-drain data: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe;
    assign edge_speed_out1_o = out1;
    assign edge_speed_out0_o = out0;
    assign edge_speed_feedback_o = fbk;
    assign readback_length_o = bc;

endmodule

//--- core/scr_params.svh
// Offsets, field positions, reset and fixed values of the config bank
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// Bus address of this slave (arbitrary value)
`define SCR_SLAVE_ADDR 7'h5A

// Byte locations
`define SCR_OFF_DIFF_SLEW 8'h02
`define SCR_OFF_FBK_SLEW 8'h03
`define SCR_OFF_RSVD 8'h04
`define SCR_OFF_REV_VENDOR 8'h05
`define SCR_OFF_TYPE_ID 8'h06
`define SCR_OFF_BYTE_COUNT 8'h07

// Field positions
`define SCR_BIT_OUT1 5
`define SCR_BIT_OUT0 3
`define SCR_BIT_FBK 0
`define SCR_BC_MSB 4

// Reset values of writable fields
`define SCR_RST_OUT1 1'h1
`define SCR_RST_OUT0 1'h1
`define SCR_RST_FBK 1'h1
`define SCR_RST_BC 5'h08

// Fixed readback of reserved bits
`define SCR_RSVD_DIFF 8'h05
`define SCR_RSVD_FBK 8'hC6
`define SCR_RSVD_BYTE 8'hFF

// Identification values (arbitrary values)
`define SCR_REVISION 4'h3
`define SCR_VENDOR 4'hA
`define SCR_PART_CLASS 2'h2
`define SCR_PART_NUMBER 6'h2A

`endif

//--- core/scr_pkg.sv
// Types shared by the config bank design
package scr_pkg;

    // Serial engine states
    typedef enum logic [2:0] {
        SCR_IDLE,
        SCR_RX,
        SCR_RXEND,
        SCR_ACK,
        SCR_TX,
        SCR_RACK
    } scr_state_t;

    // Meaning of the next received byte
    typedef enum logic [1:0] {
        SCR_K_ADDR,
        SCR_K_INDEX,
        SCR_K_COUNT,
        SCR_K_DATA
    } scr_kind_t;

endpackage

//--- sim/scr_config_regs_monitor.sv
// Pin-level checker for the config bank, bound to the design
`timescale 1ns/1ps
module scr_config_regs_monitor (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic edge_speed_out1_o,
    input wire logic edge_speed_out0_o,
    input wire logic edge_speed_feedback_o,
    input wire logic [4:0] readback_length_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    // Pull-down held for at least eight clocks
    sequence oe_held;
        sda_oe_o [*8];
    endsequence
    chk_drive_low: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    chk_oe_idle: assert property ($fell(reset_i) |-> !sda_oe_o)
        else $error("data line pulled after reset");
    chk_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    chk_ack_held: assert property ($rose(sda_oe_o) |-> oe_held)
        else $error("pull-down released too early");
    chk_out_default: assert property ($fell(reset_i) |->
        edge_speed_out1_o && edge_speed_out0_o)
        else $error("output edge speed not fast after reset");
    chk_feedback_default: assert property ($fell(reset_i) |->
        edge_speed_feedback_o)
        else $error("feedback edge speed not fast after reset");
    chk_len_default: assert property ($fell(reset_i) |->
        readback_length_o == 5'h08)
        else $error("byte count not eight after reset");
    chk_cfg_update: assert property ($changed({edge_speed_out1_o,
        edge_speed_out0_o, edge_speed_feedback_o, readback_length_o})
        |-> !scl_i)
        else $error("setting changed while clock high");
endmodule
bind scr_config_regs scr_config_regs_monitor u_mon (.sys_clk_i, .reset_i,
    .scl_i, .sda_i, .sda_o, .sda_oe_o, .edge_speed_out1_o,
    .edge_speed_out0_o, .edge_speed_feedback_o, .readback_length_o);

//--- sim/scr_smbus_host.sv
// Behavioural bus host driving clock and open-drain data
`timescale 1ns/1ps
`include "scr_params.svh"
module scr_smbus_host (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    localparam int HALF = 12; // Clocks per bus phase
    // Bus idle: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One bus phase
    task automatic wait_half();
        repeat (HALF) @(negedge sys_clk_i);
    endtask
    // Send one bit, sample the line late in the high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low_o = !b;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        s = sda_i;
        scl_o = 1'b0;
    endtask
    // Byte MSB first plus the ninth bit
    task automatic byte_io(input logic [7:0] tx, input logic ack_in,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask
    // Start or repeated start
    task automatic start();
        sda_low_o = 1'b0;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        sda_low_o = 1'b1;
        wait_half();
        scl_o = 1'b0;
    endtask
    // Stop, leaving both lines released
    task automatic stop();
        sda_low_o = 1'b1;
        wait_half();
        scl_o = 1'b1;
        wait_half();
        sda_low_o = 1'b0;
        wait_half();
    endtask
    // Index, count, then data bytes; any missing ack is reported
    task automatic blk_write(input logic [7:0] idx, input logic [7:0] d[$],
        output logic nack);
        logic [7:0] rx;
        logic a;
        start();
        byte_io({`SCR_SLAVE_ADDR, 1'b0}, 1'b1, rx, nack);
        byte_io(idx, 1'b1, rx, a);
        nack = nack | a;
        byte_io(8'(d.size()), 1'b1, rx, a);
        nack = nack | a;
        foreach (d[i]) begin
            byte_io(d[i], 1'b1, rx, a);
            nack = nack | a;
        end
        stop();
    endtask
    // Index, repeated start, count byte then n data bytes, NACK on last
    task automatic blk_read(input logic [7:0] idx, input int n,
        output logic [7:0] q[$]);
        logic [7:0] rx;
        logic a;
        q = {};
        start();
        byte_io({`SCR_SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
        byte_io(idx, 1'b1, rx, a);
        start();
        byte_io({`SCR_SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
        for (int i = 0; i <= n; i++) begin
            byte_io(8'hFF, i == n, rx, a);
            q.push_back(rx);
        end
        stop();
    endtask
endmodule

//--- sim/testbench.sv
// Testbench for the config bank with a bus host model
`timescale 1ns/1ps
`include "scr_params.svh"
module testbench;
    logic clk = 1'b0; // Bench clock
    logic rst = 1'b1; // Bench reset
    logic scl; // Bus clock from host
    logic host_low; // Host pulls data low
    logic sda_oe; // Design pulls data low
    logic o1, o0, fbk; // Edge speed outputs
    logic [4:0] len; // Programmed count
    wire sda_line = !(host_low || sda_oe); // Pulled-up data line
    int m_o1 = 1, m_o0 = 1, m_fbk = 1, m_bc = 8; // Reference model
    int miscompares = 0;
    int checked = 0;
    scr_config_regs DUT (.sys_clk_i(clk), .reset_i(rst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
        .edge_speed_out1_o(o1), .edge_speed_out0_o(o0),
        .edge_speed_feedback_o(fbk), .readback_length_o(len));
    scr_smbus_host host (.sys_clk_i(clk), .sda_i(sda_line), .scl_o(scl),
        .sda_low_o(host_low));
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Expected readback of each location
    function automatic logic [7:0] exp_byte(int i);
        case (i)
            2: return `SCR_RSVD_DIFF | (8'(m_o1) << `SCR_BIT_OUT1)
                | (8'(m_o0) << `SCR_BIT_OUT0);
            3: return `SCR_RSVD_FBK | 8'(m_fbk);
            4: return `SCR_RSVD_BYTE;
            5: return {`SCR_REVISION, `SCR_VENDOR};
            6: return {`SCR_PART_CLASS, `SCR_PART_NUMBER};
            7: return 8'(m_bc);
            default: return 8'h00;
        endcase
    endfunction
    // Compare and report
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Outputs and a full block read against the model
    task automatic verify(string name);
        logic [7:0] q[$];
        chk("out1", 8'(m_o1), 8'(o1));
        chk("out0", 8'(m_o0), 8'(o0));
        chk("feedback", 8'(m_fbk), 8'(fbk));
        chk("length", 8'(m_bc), 8'(len));
        host.blk_read(8'h00, 8, q);
        chk("count byte", 8'(m_bc), q[0]);
        for (int i = 0; i < 8; i++) begin
            chk($sformatf("byte %0d", i), exp_byte(i), q[i + 1]);
        end
        $display("Test %s done", name);
    endtask
    // Verdict
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [7:0] d[$];
        logic [7:0] q[$];
        logic [7:0] rx;
        logic nack;
        void'($urandom(74));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        verify("defaults");
        repeat (4) begin
            d = {};
            for (int i = 0; i < 8; i++) begin
                d.push_back(8'($urandom));
            end
            host.blk_write(8'h00, d, nack);
            chk("write ack", 8'h00, 8'(nack));
            m_o1 = int'(d[2][5]);
            m_o0 = int'(d[2][3]);
            m_fbk = int'(d[3][0]);
            m_bc = int'(d[7][4:0]);
            verify("random write");
        end
        // One byte at a nonzero index, then a short read past the top
        d = {8'($urandom)};
        host.blk_write(`SCR_OFF_FBK_SLEW, d, nack);
        chk("short write ack", 8'h00, 8'(nack));
        m_fbk = int'(d[0][0]);
        host.blk_read(`SCR_OFF_BYTE_COUNT, 2, q);
        chk("short count", 8'(m_bc), q[0]);
        chk("short byte 7", exp_byte(7), q[1]);
        chk("short byte 8", 8'h00, q[2]);
        verify("short transfers");
        host.start();
        host.byte_io({`SCR_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, nack);
        host.stop();
        chk("foreign address", 8'h01, 8'(nack));
        verify("foreign address");
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        m_o1 = 1;
        m_o0 = 1;
        m_fbk = 1;
        m_bc = 8;
        repeat (10) @(negedge clk);
        verify("second reset");
        complete_run();
    end
    // Watchdog
    initial begin
        #400us;
        miscompares++;
        complete_run();
    end
endmodule
